// file: shared/fir_defines.svh
// Constants for the fabric interrupt router: offsets, fields, resets, source slots
// Operation
// R1 - Accept 24 active-high level interrupt sources
// R2 - Drive 16-bit fabric interrupt bus
// R3 - Output takes dedicated or group source
// R4 - One mode bit picks group 0/1
// R5 - Source passes only when enable set
// R6 - Dedicated sources ignore group select
// R7 - Dedicated slots 15, 9, 8, 0
// R8 - Group 0 source table
// R9 - Group 1 source table
// R10 - Output 5 never asserts
// R11 - Overlaid sources OR together
// R12 - Fabric finds originator via peripheral status
// R13 - Inputs to outputs purely combinational
// R14 - Router neither latches nor clears sources
// R15 - Fabric outputs are active high
// R16 - Separate comm-block interrupt output
// R17 - Five registers, all reset to zero
// R18 - Active registers show live sources
// R19 - Mode selects group, group 0 default
// R20 - Output is OR of enabled paths
`ifndef FIR_DEFINES_SVH
`define FIR_DEFINES_SVH

// Counts
`define FIR_NUM_SRC 24
`define FIR_NUM_OUT 16
`define FIR_LOW_SRC 16

// Register byte offsets
`define FIR_OFS_ENABLE_LOW 12'h000
`define FIR_OFS_ENABLE_HIGH 12'h004
`define FIR_OFS_ACTIVE_LOW 12'h008
`define FIR_OFS_ACTIVE_HIGH 12'h00C
`define FIR_OFS_MODE 12'h010
`define FIR_OFS_WIDTH 12

// Reset values and fields
`define FIR_RST_REG 32'h0000_0000
`define FIR_MODE_SEL_BIT 0

// AHB-Lite codes
`define FIR_HSIZE_WORD 3'h2
`define FIR_HTRANS_BIT 1

// Source slots in the source vector
`define FIR_SRC_MEM_PLL_LOST 5'h00
`define FIR_SRC_HP_DMA_DONE 5'h01
`define FIR_SRC_PERIPH_DMA 5'h02
`define FIR_SRC_SERIAL_PERIPH0 5'h03
`define FIR_SRC_COMM_BLOCK_A 5'h04
`define FIR_SRC_SOFTWARE 5'h05
`define FIR_SRC_ECC_ERROR 5'h06
`define FIR_SRC_MEM_BRIDGE 5'h07
`define FIR_SRC_BUS_ERROR 5'h08
`define FIR_SRC_MEM_PLL_LOCKED 5'h09
`define FIR_SRC_HP_DMA_ERROR 5'h0A
`define FIR_SRC_NVM0 5'h0B
`define FIR_SRC_NVM1 5'h0C
`define FIR_SRC_WIDE_PORT 5'h0D
`define FIR_SRC_FAB_PLL_LOST 5'h0E
`define FIR_SRC_FAB_PLL_LOCKED 5'h0F
`define FIR_SRC_MEM_IO_CALIB 5'h10
`define FIR_SRC_COMM_BLOCK_B 5'h11
`define FIR_SRC_SPARE 5'h12
`define FIR_SRC_NONE 5'h1F

`endif

// file: shared/fir_pkg.sv
// Types shared by the fabric interrupt router files
package fir_pkg;
   typedef logic [31:0] fir_word_t;
   typedef logic [23:0] fir_src_vec_t;
   typedef logic [15:0] fir_irq_vec_t;
   typedef logic [4:0] fir_src_idx_t;
   typedef logic [5:0] fir_spare_vec_t;
   typedef enum logic {FIR_GROUP0, FIR_GROUP1} fir_group_t;
endpackage

// file: design/fir_route_map.sv
// Combinational routing of gated sources onto the fabric interrupt bus
`timescale 1ns/1ps
`include "fir_defines.svh"
module fir_route_map (
   input wire fir_pkg::fir_src_vec_t srcLevel,
   input wire fir_pkg::fir_src_vec_t srcEnable,
   input wire fir_pkg::fir_group_t groupSel,
   output logic [`FIR_NUM_OUT-1:0] fabricIrq
);
   import fir_pkg::*;

   // Source tables, entry 15 first; NONE picks a constant zero
   localparam fir_src_idx_t [15:0] DEDICATED = {
      `FIR_SRC_MEM_PLL_LOST, {5{`FIR_SRC_NONE}}, `FIR_SRC_HP_DMA_DONE, // R7
      `FIR_SRC_PERIPH_DMA, {7{`FIR_SRC_NONE}}, `FIR_SRC_SERIAL_PERIPH0}; // R7
   localparam fir_src_idx_t [15:0] GROUP0 = {
      `FIR_SRC_COMM_BLOCK_A, `FIR_SRC_SOFTWARE, `FIR_SRC_NONE, `FIR_SRC_ECC_ERROR, // R8
      `FIR_SRC_MEM_BRIDGE, `FIR_SRC_BUS_ERROR, `FIR_SRC_MEM_PLL_LOCKED, // R8
      `FIR_SRC_HP_DMA_ERROR, {6{`FIR_SRC_NONE}}, `FIR_SRC_NVM1, `FIR_SRC_NVM0}; // R8
   localparam fir_src_idx_t [15:0] GROUP1 = {
      `FIR_SRC_WIDE_PORT, `FIR_SRC_FAB_PLL_LOST, `FIR_SRC_FAB_PLL_LOCKED, // R9
      `FIR_SRC_NONE, `FIR_SRC_MEM_IO_CALIB, {3{`FIR_SRC_NONE}}, // R9
      `FIR_SRC_COMM_BLOCK_B, `FIR_SRC_SOFTWARE, `FIR_SRC_NONE, `FIR_SRC_ECC_ERROR, // R9 R10
      `FIR_SRC_MEM_BRIDGE, `FIR_SRC_BUS_ERROR, `FIR_SRC_MEM_PLL_LOCKED, `FIR_SRC_HP_DMA_ERROR}; // R9

   // Masked sources, widened so unused slots read zero
   wire fir_src_vec_t gated = srcLevel & srcEnable; // R5
   wire [31:0] gatedWide = {8'h00, gated}; // R20

   // One OR gate per output, no storage anywhere
   genvar i;
   generate
      for (i = 0; i < `FIR_NUM_OUT; i = i + 1) begin : gRoute
         wire dedBit = gatedWide[DEDICATED[i]]; // R6
         wire grpBit = (groupSel == FIR_GROUP1) ? gatedWide[GROUP1[i]] : gatedWide[GROUP0[i]]; // R3 R4
         assign fabricIrq[i] = dedBit | grpBit; // R11 R13 R20
      end
   endgenerate
endmodule // fir_route_map

// file: design/fir_router.sv
// Fabric interrupt router top: AHB-Lite registers and asynchronous routing
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "fir_defines.svh"
module fir_router (
   input wire logic clk,
   input wire logic rstn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire fir_pkg::fir_word_t haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [2:0] hburst,
   input wire logic [3:0] hprot,
   input wire logic hmastlock,
   input wire logic hready,
   input wire fir_pkg::fir_word_t hwdata,
   output logic hreadyout,
   output logic hresp,
   output fir_pkg::fir_word_t hrdata,
   // Peripheral interrupt sources, active high levels
   input wire logic mem_pll_lost_irq,
   input wire logic hp_dma_done_irq,
   input wire logic periph_dma_irq,
   input wire logic serial_periph0_irq,
   input wire logic comm_block_irq_a,
   input wire logic software_irq,
   input wire logic ecc_error_irq,
   input wire logic mem_bridge_irq,
   input wire logic bus_error_irq,
   input wire logic mem_pll_locked_irq,
   input wire logic hp_dma_error_irq,
   input wire logic nvm_irq0,
   input wire logic nvm_irq1,
   input wire logic wide_fabric_port_irq,
   input wire logic fabric_pll_lost_irq,
   input wire logic fabric_pll_locked_irq,
   input wire logic mem_io_calib_irq,
   input wire logic comm_block_irq_b,
   input wire fir_pkg::fir_spare_vec_t spare_irq,
   // Toward the fabric
   output fir_pkg::fir_irq_vec_t fabric_irq_out,
   output logic comm_block_irq_out
);
   import fir_pkg::*;

   // Source vector in slot order
   wire fir_src_vec_t srcLevel; // R1
   assign srcLevel[`FIR_SRC_MEM_PLL_LOST] = mem_pll_lost_irq;
   assign srcLevel[`FIR_SRC_HP_DMA_DONE] = hp_dma_done_irq;
   assign srcLevel[`FIR_SRC_PERIPH_DMA] = periph_dma_irq;
   assign srcLevel[`FIR_SRC_SERIAL_PERIPH0] = serial_periph0_irq;
   assign srcLevel[`FIR_SRC_COMM_BLOCK_A] = comm_block_irq_a;
   assign srcLevel[`FIR_SRC_SOFTWARE] = software_irq;
   assign srcLevel[`FIR_SRC_ECC_ERROR] = ecc_error_irq;
   assign srcLevel[`FIR_SRC_MEM_BRIDGE] = mem_bridge_irq;
   assign srcLevel[`FIR_SRC_BUS_ERROR] = bus_error_irq;
   assign srcLevel[`FIR_SRC_MEM_PLL_LOCKED] = mem_pll_locked_irq;
   assign srcLevel[`FIR_SRC_HP_DMA_ERROR] = hp_dma_error_irq;
   assign srcLevel[`FIR_SRC_NVM0] = nvm_irq0;
   assign srcLevel[`FIR_SRC_NVM1] = nvm_irq1;
   assign srcLevel[`FIR_SRC_WIDE_PORT] = wide_fabric_port_irq;
   assign srcLevel[`FIR_SRC_FAB_PLL_LOST] = fabric_pll_lost_irq;
   assign srcLevel[`FIR_SRC_FAB_PLL_LOCKED] = fabric_pll_locked_irq;
   assign srcLevel[`FIR_SRC_MEM_IO_CALIB] = mem_io_calib_irq;
   assign srcLevel[`FIR_SRC_COMM_BLOCK_B] = comm_block_irq_b;
   assign srcLevel[`FIR_SRC_SPARE +: 6] = spare_irq;

   // Software visible configuration
   fir_word_t irq_enable_low;
   fir_word_t irq_enable_high;
   fir_group_t groupSel;

   // Per-source enable, low register covers slots 0 to 15
   wire fir_src_vec_t srcEnable = {irq_enable_high[`FIR_NUM_SRC-`FIR_LOW_SRC-1:0],
                                   irq_enable_low[`FIR_LOW_SRC-1:0]}; // R5

   // Asynchronous routing core
   fir_route_map uMap (
      .srcLevel(srcLevel),
      .srcEnable(srcEnable),
      .groupSel(groupSel),
      .fabricIrq(fabric_irq_out) // R2 R15
   );

   // Comm block line passes straight through, unmasked
   assign comm_block_irq_out = comm_block_irq_a; // R16 R14

   // Two-stage synchroniser for the status view only
   fir_src_vec_t srcMeta;
   fir_src_vec_t srcSync;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         srcMeta <= '0;
         srcSync <= '0;
      end else begin
         srcMeta <= srcLevel;
         srcSync <= srcMeta;
      end
   end

   // Live source levels, split over the two status words
   wire fir_word_t active_irq_low = {16'h0000, srcSync[`FIR_LOW_SRC-1:0]}; // R18
   wire fir_word_t active_irq_high = {24'h00_0000, srcSync[`FIR_NUM_SRC-1:`FIR_LOW_SRC]}; // R18
   wire fir_word_t modeWord = {31'h0000_0000, groupSel == FIR_GROUP1};

   // Address phase acceptance
   wire addrTaken = hsel & hready & htrans[`FIR_HTRANS_BIT];
   wire [`FIR_OFS_WIDTH-1:0] addrOfs = haddr[`FIR_OFS_WIDTH-1:0];

   // Data phase state captured from the address phase
   logic wrPending;
   logic [`FIR_OFS_WIDTH-1:0] wrOfs;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wrPending <= 1'b0;
         wrOfs <= '0;
      end else begin
         wrPending <= addrTaken & hwrite & (hsize == `FIR_HSIZE_WORD);
         wrOfs <= addrOfs;
      end
   end

   // Write decode in the data phase
   wire wrEnLow = wrPending & (wrOfs == `FIR_OFS_ENABLE_LOW);
   wire wrEnHigh = wrPending & (wrOfs == `FIR_OFS_ENABLE_HIGH);
   wire wrMode = wrPending & (wrOfs == `FIR_OFS_MODE);

   // Next values of the writable registers
   wire fir_word_t next_irq_enable_low = wrEnLow ? hwdata : irq_enable_low;
   wire fir_word_t next_irq_enable_high = wrEnHigh ? hwdata : irq_enable_high;
   wire fir_group_t next_groupSel = wrMode ? fir_group_t'(hwdata[`FIR_MODE_SEL_BIT]) : groupSel;

   // Configuration registers, all cleared so every source starts masked
   always_ff @(posedge clk) begin
      if (!rstn) begin
         irq_enable_low <= `FIR_RST_REG; // R17
         irq_enable_high <= `FIR_RST_REG; // R17
         groupSel <= FIR_GROUP0; // R19
      end else begin
         irq_enable_low <= next_irq_enable_low;
         irq_enable_high <= next_irq_enable_high;
         groupSel <= next_groupSel; // R4 R19
      end
   end

   // Read selection; a write in flight is forwarded to a following read
   wire rdNow = addrTaken & ~hwrite;
   wire fir_word_t rdEnLow = (wrEnLow) ? hwdata : irq_enable_low;
   wire fir_word_t rdEnHigh = (wrEnHigh) ? hwdata : irq_enable_high;
   wire fir_word_t rdMode = (wrMode) ? {31'h0000_0000, hwdata[`FIR_MODE_SEL_BIT]} : modeWord;
   wire fir_word_t rdValue =
      (addrOfs == `FIR_OFS_ENABLE_LOW) ? rdEnLow :
      (addrOfs == `FIR_OFS_ENABLE_HIGH) ? rdEnHigh :
      (addrOfs == `FIR_OFS_ACTIVE_LOW) ? active_irq_low :
      (addrOfs == `FIR_OFS_ACTIVE_HIGH) ? active_irq_high :
      (addrOfs == `FIR_OFS_MODE) ? rdMode :
      `FIR_RST_REG; // Unmapped reads zero
   wire fir_word_t next_hrdata = rdNow ? rdValue : `FIR_RST_REG;

   // Read data register for the data phase
   always_ff @(posedge clk) begin
      if (!rstn) begin
         hrdata <= `FIR_RST_REG;
      end else begin
         hrdata <= next_hrdata;
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule // fir_router

// file: verification/fir_router_properties.sv
// Port-level properties of the fabric interrupt router
`timescale 1ns/1ps
module fir_router_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire fir_pkg::fir_word_t hrdata,
   input wire logic mem_pll_lost_irq,
   input wire logic comm_block_irq_a,
   input wire logic wide_fabric_port_irq,
   input wire logic comm_block_irq_b,
   input wire fir_pkg::fir_irq_vec_t fabric_irq_out,
   input wire logic comm_block_irq_out
);
   import fir_pkg::*;
   logic rdPhase;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // Marks the data phase of a read
   always_ff @(posedge clk) begin
      rdPhase <= rstn & hsel & hready & htrans[1] & ~hwrite;
   end
   a_ready_high: assert property (hreadyout) else $error("slave stalled");
   a_resp_okay: assert property (!hresp) else $error("error response");
   a_hrdata_idle: assert property (!rdPhase |-> hrdata == 32'h0000_0000) else $error("stray read data");
   a_reset_masked: assert property ($rose(rstn) |-> fabric_irq_out == 16'h0000) else $error("unmasked");
   a_out5_quiet: assert property (fabric_irq_out[5] == 1'b0) else $error("output 5 raised");
   a_comm_direct: assert property (comm_block_irq_out == comm_block_irq_a) else $error("comm out");
   a_top_sources: assert property (fabric_irq_out[15] |-> mem_pll_lost_irq | comm_block_irq_a |
      wide_fabric_port_irq) else $error("output 15 without source");
   a_seven_source: assert property (fabric_irq_out[7] |-> comm_block_irq_b) else $error("output 7");
endmodule // fir_router_properties

bind fir_router fir_router_properties u_props (.clk(clk), .rstn(rstn), .hsel(hsel), .hready(hready),
   .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .mem_pll_lost_irq(mem_pll_lost_irq), .comm_block_irq_a(comm_block_irq_a),
   .wide_fabric_port_irq(wide_fabric_port_irq), .comm_block_irq_b(comm_block_irq_b),
   .fabric_irq_out(fabric_irq_out), .comm_block_irq_out(comm_block_irq_out));

// file: verification/fir_fabric_model.sv
// Fabric-side user logic that records routed interrupt lines
`timescale 1ns/1ps
module fir_fabric_model (
   input wire logic clk,
   input wire logic rstn,
   input wire fir_pkg::fir_irq_vec_t irqIn,
   output fir_pkg::fir_irq_vec_t seen
);
   import fir_pkg::*;
   // Lines seen; originator is found later from source status
   always_ff @(posedge clk) begin
      if (!rstn) begin
         seen <= 16'h0000;
      end else begin
         seen <= seen | irqIn;
      end
   end
endmodule // fir_fabric_model

// file: verification/fir_router_tb_top.sv
// Self-checking bench for the fabric interrupt router
`timescale 1ns/1ps
module fir_router_tb_top;
   import fir_pkg::*;
   logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, mode = 0, hreadyout, hresp, commOut;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'h2;
   fir_word_t haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd, enL, enH, wd;
   fir_src_vec_t src = 24'h00_0000;
   fir_irq_vec_t fab, seen, acc = 16'h0000;
   int failCount = 0, nChecks = 0;
   int ded[16] = '{3, 31, 31, 31, 31, 31, 31, 31, 2, 1, 31, 31, 31, 31, 31, 0};
   int g0[16] = '{11, 12, 31, 31, 31, 31, 31, 31, 10, 9, 8, 7, 6, 31, 5, 4};
   int g1[16] = '{10, 9, 8, 7, 6, 31, 5, 17, 31, 31, 31, 16, 31, 15, 14, 13};
   always #25 clk = ~clk;
   fir_router uut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hburst(3'h0), .hprot(4'h3), .hmastlock(1'b0), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem_pll_lost_irq(src[0]),
      .hp_dma_done_irq(src[1]), .periph_dma_irq(src[2]), .serial_periph0_irq(src[3]),
      .comm_block_irq_a(src[4]), .software_irq(src[5]), .ecc_error_irq(src[6]), .mem_bridge_irq(src[7]),
      .bus_error_irq(src[8]), .mem_pll_locked_irq(src[9]), .hp_dma_error_irq(src[10]), .nvm_irq0(src[11]),
      .nvm_irq1(src[12]), .wide_fabric_port_irq(src[13]), .fabric_pll_lost_irq(src[14]),
      .fabric_pll_locked_irq(src[15]), .mem_io_calib_irq(src[16]), .comm_block_irq_b(src[17]),
      .spare_irq(src[23:18]), .fabric_irq_out(fab), .comm_block_irq_out(commOut));
   fir_fabric_model fabModel (.clk(clk), .rstn(rstn), .irqIn(fab), .seen(seen));
   // One single AHB-Lite transfer, word sized unless s is given
   task automatic bus(input logic w, input logic [11:0] a, input fir_word_t d, output fir_word_t r,
      input logic [2:0] s = 3'h2);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= s;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic chk(input fir_word_t e, input fir_word_t g);
      nChecks++;
      if (g !== e) begin
         failCount++;
         $display("unexpected at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   // Reference routing from the source tables
   function automatic fir_irq_vec_t model_irq();
      logic [31:0] en, sx;
      fir_irq_vec_t e;
      en = {enH[15:0], enL[15:0]};
      sx = {8'h00, src};
      for (int i = 0; i < 16; i++) begin
         e[i] = (sx[ded[i]] & en[ded[i]]) | (sx[mode ? g1[i] : g0[i]] & en[mode ? g1[i] : g0[i]]);
      end
      return e;
   endfunction
   // Reset with live sources: fabric outputs masked, comm output follows its source, every register reads zero
   task automatic reset_check();
      rstn <= 1'b0;
      src <= 24'($urandom);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(32'h0000_0000, 32'(fab));
      chk(32'(src[4]), 32'(commOut));
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      src <= 24'h00_0000;
      for (int a = 0; a < 24; a += 4) begin
         bus(1'b0, a[11:0], 32'h0000_0000, rd);
         chk(32'h0000_0000, rd);
      end
      $display("reset values done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      failCount++;
      close_out();
   end
   initial begin
      void'($urandom(32'h0de7_f34c));
      reset_check();
      for (int k = 0; k < 40; k++) begin
         @(posedge clk);
         src <= 24'h00_0000;
         enL = $urandom;
         enH = $urandom;
         wd = $urandom;
         mode = wd[0];
         bus(1'b1, 12'h000, enL, rd);
         bus(1'b1, 12'h004, enH, rd);
         bus(1'b1, 12'h010, wd, rd);
         @(posedge clk);
         src <= 24'($urandom);
         @(negedge clk);
         chk(32'(model_irq()), 32'(fab));
         chk(32'(src[4]), 32'(commOut));
         acc = acc | model_irq();
         @(posedge clk);
         src <= ~src;
         @(negedge clk);
         chk(32'(model_irq()), 32'(fab));
         acc = acc | model_irq();
         bus(1'b1, 12'h000, ~enL, rd, 3'h0); // Sub-word write, ignored
         bus(1'b0, 12'h000, 32'h0000_0000, rd);
         chk(enL, rd);
         bus(1'b0, 12'h004, 32'h0000_0000, rd);
         chk(enH, rd);
         bus(1'b0, 12'h010, 32'h0000_0000, rd);
         chk({31'h0000_0000, mode}, rd);
         bus(1'b1, 12'h008, wd, rd);
         bus(1'b0, 12'h008, 32'h0000_0000, rd);
         chk({16'h0000, src[15:0]}, rd);
         bus(1'b0, 12'h00C, 32'h0000_0000, rd);
         chk({24'h00_0000, src[23:16]}, rd);
      end
      $display("random routing done");
      repeat (2) @(posedge clk);
      chk(32'(acc), 32'(seen));
      $display("fabric view done");
      reset_check();
      close_out();
   end
endmodule // fir_router_tb_top
